// File: shared/memcard_status_pkg.sv
// Constants and types shared by the status and response logic
package memcard_status_pkg;

    // Short status byte bit positions, sent MSB first
    localparam int SB_IDLE        = 0;
    localparam int SB_ERASE_RESET = 1;
    localparam int SB_ILLEGAL     = 2;
    localparam int SB_CRC         = 3;
    localparam int SB_ERASE_SEQ   = 4;
    localparam int SB_ADDR        = 5;
    localparam int SB_PARAM       = 6;
    localparam int SB_ZERO        = 7;

    // Second byte of the extended status response
    localparam int EB_LOCKED      = 0;
    localparam int EB_SKIP_LOCKF  = 1;
    localparam int EB_ERROR       = 2;
    localparam int EB_CC          = 3;
    localparam int EB_ECC         = 4;
    localparam int EB_WP_VIOL     = 5;
    localparam int EB_ERASE_PARAM = 6;
    localparam int EB_RANGE_OVR   = 7;

    // Generic error event inputs; same index as their latch
    localparam int GE_PARAM       = 0;
    localparam int GE_ADDR        = 1;
    localparam int GE_ERASE_SEQ   = 2;
    localparam int GE_CRC         = 3;
    localparam int GE_ILLEGAL     = 4;
    localparam int GE_RANGE       = 5;
    localparam int GE_ERASE_PARAM = 6;
    localparam int GE_WP_VIOL     = 7;
    localparam int GE_ECC         = 8;
    localparam int GE_CC          = 9;
    localparam int GE_ERROR       = 10;
    localparam int GE_W           = 11;

    // Further clear-on-read latches
    localparam int FL_OVERWRITE   = 11;
    localparam int FL_SKIP        = 12;
    localparam int FL_LOCKFAIL    = 13;
    localparam int FL_ERASE_RESET = 14;
    localparam int FL_W           = 15;

    // Latches cleared when each byte is delivered
    localparam logic [FL_W-1:0] SHORT_CLR_MASK = 15'h401F;
    localparam logic [FL_W-1:0] EXT_CLR_MASK   = 15'h3FE0;
    localparam logic [FL_W-1:0] FLAGS_RST      = 15'h0000;
    localparam logic            IDLE_RST       = 1'h1;

    // Line bytes
    localparam logic [7:0] IDLE_BYTE   = 8'hFF;
    localparam logic [7:0] BUSY_BYTE   = 8'h00;
    localparam logic [7:0] START_TOKEN = 8'hFE;

    // Byte counts and timing, in serial bytes of 8 clocks
    localparam int CLOCKS_PER_UNIT      = 8;
    localparam int RESP_GAP_BYTES       = 1;
    localparam int REG_DATA_LIMIT_UNITS = 8;
    localparam int REG_WAIT_BYTES       = 1;
    localparam logic [4:0] OCR_LAST     = 5'h03;
    localparam logic [4:0] REG_LAST     = 5'h11;
    localparam logic [2:0] BIT_LAST     = 3'h7;

    // Pin synchroniser reset: clock low, chip select high
    localparam logic [1:0] PIN_SYNC_RST = 2'h2;
    localparam int PIN_SCK  = 0;
    localparam int PIN_CS_N = 1;

    // Response kinds a command may ask for
    typedef enum logic [2:0] {
        KIND_SHORT = 3'h0,
        KIND_BUSY  = 3'h1,
        KIND_EXT   = 3'h2,
        KIND_OCR   = 3'h3,
        KIND_SPEC  = 3'h4,
        KIND_IDENT = 3'h5
    } resp_kind_t;

    // Transmit sequencer, Gray coded in declaration order
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_GAP  = 3'h1,
        ST_TAIL = 3'h3,
        ST_WAIT = 3'h2,
        ST_DATA = 3'h6,
        ST_BUSY = 3'h7
    } tx_state_t;

endpackage : memcard_status_pkg

// File: shared/memcard_ifs.sv
// Carriers between synchroniser, status latches and transmitter
`timescale 1ns/1ps

interface spi_pins_if;
    logic sck_fall;
    logic cs_low;
    logic cs_rise;
    logic cs_fall;
    modport drv  (output sck_fall, cs_low, cs_rise, cs_fall);
    modport sink (input  sck_fall, cs_low, cs_rise, cs_fall);
endinterface : spi_pins_if

interface status_if;
    logic [7:0] short_byte;
    logic [7:0] ext_byte;
    logic       idle;
    logic       rd_short;
    logic       rd_ext;
    modport flags (output short_byte, ext_byte, idle, input rd_short, rd_ext);
    modport tx    (input short_byte, ext_byte, idle, output rd_short, rd_ext);
endinterface : status_if

// File: hdl/spi_pin_sync.sv
// Two-stage synchroniser and edge finder for the serial pins
`timescale 1ns/1ps

module spi_pin_sync (
    // Clock and reset
    input  wire logic  clk_in,
    input  wire logic  rst_in,
    // Raw pins
    input  wire logic  sck_in,
    input  wire logic  cs_n_in,
    // Synchronised events
    spi_pins_if.drv    pins
);

    logic [1:0] meta_r;
    logic [1:0] stab_r;
    logic [1:0] prev_r;
    logic [1:0] raw;
    logic [1:0] fall;

    assign raw = {cs_n_in, sck_in};

    // Meta stage feeds only the stable stage
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r <= memcard_status_pkg::PIN_SYNC_RST;
            stab_r <= memcard_status_pkg::PIN_SYNC_RST;
            prev_r <= memcard_status_pkg::PIN_SYNC_RST;
        end else begin
            meta_r <= raw;
            stab_r <= meta_r;
            prev_r <= stab_r;
        end
    end

    // Edge pulses from the stable and delayed stages
    assign fall          = prev_r & ~stab_r;
    assign pins.sck_fall = fall[memcard_status_pkg::PIN_SCK];
    assign pins.cs_low   = ~stab_r[memcard_status_pkg::PIN_CS_N];
    assign pins.cs_fall  = fall[memcard_status_pkg::PIN_CS_N];
    assign pins.cs_rise  = stab_r[memcard_status_pkg::PIN_CS_N]
                         & ~prev_r[memcard_status_pkg::PIN_CS_N];

endmodule : spi_pin_sync

// File: hdl/card_status_flags.sv
// Shared status latches and the status bytes built from them
`timescale 1ns/1ps

module card_status_flags (
    // Clock and reset
    input  wire logic                                   clk_in,
    input  wire logic                                   rst_in,
    // Event pulses
    input  wire logic [memcard_status_pkg::GE_W-1:0]    gen_err_in,
    input  wire logic                                   spec_ro_mismatch_in,
    input  wire logic                                   spec_guard_undo_in,
    input  wire logic                                   erase_partial_in,
    input  wire logic                                   lock_seq_err_in,
    input  wire logic                                   lock_pwd_err_in,
    input  wire logic                                   erase_abandon_in,
    input  wire logic                                   reset_cmd_in,
    input  wire logic                                   init_done_in,
    // Lock state level
    input  wire logic                                   password_locked_in,
    // Bytes and read strobes
    status_if.flags                                     st
);

    logic [memcard_status_pkg::FL_W-1:0] flag_r;
    logic [memcard_status_pkg::FL_W-1:0] flag_nxt;
    logic [memcard_status_pkg::FL_W-1:0] set;
    logic [memcard_status_pkg::FL_W-1:0] clr;
    logic [memcard_status_pkg::FL_W-1:0] view;
    logic                                idle_r;
    logic                                idle_nxt;

    // Events into the shared latch vector
    assign set[memcard_status_pkg::GE_W-1:0] = gen_err_in;
    assign set[memcard_status_pkg::FL_OVERWRITE]   = spec_ro_mismatch_in
        | spec_guard_undo_in; // [R1]
    assign set[memcard_status_pkg::FL_SKIP]        = erase_partial_in;                  // [R2]
    assign set[memcard_status_pkg::FL_LOCKFAIL]    = lock_seq_err_in | lock_pwd_err_in; // [R3]
    assign set[memcard_status_pkg::FL_ERASE_RESET] = erase_abandon_in;                  // [R5]

    // Clear masks follow the byte delivered
    assign clr = (st.rd_short ? memcard_status_pkg::SHORT_CLR_MASK : '0)
               | (st.rd_ext   ? memcard_status_pkg::EXT_CLR_MASK   : '0); // [R20] [R9]
    assign flag_nxt = (flag_r & ~clr) | set; // [R21] [R1] [R2] [R3] [R5]
    assign view     = flag_r | set;          // [R7]

    // Idle until initialisation ends; reset command re-enters it
    assign idle_nxt = reset_cmd_in ? 1'b1 : (init_done_in ? 1'b0 : idle_r); // [R6] [R9]

    // Latch update
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flag_r <= memcard_status_pkg::FLAGS_RST;
            idle_r <= memcard_status_pkg::IDLE_RST;
        end else begin
            flag_r <= flag_nxt;
            idle_r <= idle_nxt;
        end
    end

    // Short status byte, top bit zero
    assign st.short_byte = {1'b0,
                            view[memcard_status_pkg::GE_PARAM],
                            view[memcard_status_pkg::GE_ADDR],
                            view[memcard_status_pkg::GE_ERASE_SEQ],
                            view[memcard_status_pkg::GE_CRC],
                            view[memcard_status_pkg::GE_ILLEGAL],
                            view[memcard_status_pkg::FL_ERASE_RESET],
                            idle_r}; // [R17] [R5] [R6]

    // Extended second byte; lock bit is live
    assign st.ext_byte = {view[memcard_status_pkg::GE_RANGE]
                              | view[memcard_status_pkg::FL_OVERWRITE],
                          view[memcard_status_pkg::GE_ERASE_PARAM],
                          view[memcard_status_pkg::GE_WP_VIOL],
                          view[memcard_status_pkg::GE_ECC],
                          view[memcard_status_pkg::GE_CC],
                          view[memcard_status_pkg::GE_ERROR],
                          view[memcard_status_pkg::FL_SKIP]
                              | view[memcard_status_pkg::FL_LOCKFAIL],
                          password_locked_in}; // [R18] [R1] [R2] [R3] [R4]

    assign st.idle = idle_r;

endmodule : card_status_flags

// File: hdl/memcard_spi_status_busy_timing.sv
// Response transmitter with status bookkeeping and busy signalling
//
// Summary of operation
// R1 - Overwrite error set on mismatch or undo
// R2 - Partial guarded erase sets skip flag
// R3 - Lock sequence or password error sets flag
// R4 - Locked bit mirrors live password lock
// R5 - Abandoned erase sequence sets erase-reset flag
// R6 - Idle bit high until initialisation completes
// R7 - Response flags appear in causing response
// R8 - Host polls status for execution flags
// R9 - State bits live, error bits clear-on-read
// R10 - Host clocks response gap after responses
// R11 - Host may deselect during busy anytime
// R12 - Output released one clock after deselect
// R13 - Host reselects to probe busy state
// R14 - Reselect while busy drives output low
// R15 - Register data starts within eight byte units
// R16 - Only condition, spec, ident registers readable
// R17 - Short status: one byte, top bit zero
// R18 - Extended status: short byte plus flags
// R19 - Zero bytes while busy, then non-zero
// R20 - One latch per flag across formats
// R21 - New event beats same-cycle clear
`timescale 1ns/1ps

module memcard_spi_status_busy_timing #(
    parameter int RESP_GAP_BYTES = memcard_status_pkg::RESP_GAP_BYTES,
    parameter int REG_WAIT_BYTES = memcard_status_pkg::REG_WAIT_BYTES
) (
    // Clock and reset
    input  wire logic                                 CLK_IN,
    input  wire logic                                 RST_IN,
    // Serial pins
    input  wire logic                                 SCK_IN,
    input  wire logic                                 CS_N_IN,
    output logic                                      CARD_SERIAL_OUT,
    output logic                                      CARD_SERIAL_OE_OUT,
    // Response requests
    input  wire logic                                 RESP_REQ_IN,
    input  wire logic [2:0]                           RESP_KIND_IN,
    output logic                                      RESP_READY_OUT,
    output logic                                      RESP_DONE_OUT,
    input  wire logic                                 BUSY_IN,
    // Register contents
    input  wire logic [31:0]                          OCR_IN,
    input  wire logic [127:0]                         SPEC_REG_IN,
    input  wire logic [127:0]                         IDENT_REG_IN,
    input  wire logic [15:0]                          REG_CRC_IN,
    // Status events
    input  wire logic [memcard_status_pkg::GE_W-1:0]  GEN_ERR_IN,
    input  wire logic                                 SPEC_RO_MISMATCH_IN,
    input  wire logic                                 SPEC_GUARD_UNDO_IN,
    input  wire logic                                 ERASE_PARTIAL_IN,
    input  wire logic                                 LOCK_SEQ_ERR_IN,
    input  wire logic                                 LOCK_PWD_ERR_IN,
    input  wire logic                                 ERASE_ABANDON_IN,
    input  wire logic                                 RESET_CMD_IN,
    input  wire logic                                 INIT_DONE_IN,
    input  wire logic                                 PASSWORD_LOCKED_IN,
    // Status outputs
    output logic                                      IDLE_STATE_OUT,
    output logic                                      TX_ACTIVE_OUT
);

    spi_pins_if pins ();
    status_if   st ();

    memcard_status_pkg::tx_state_t  state_r;
    memcard_status_pkg::tx_state_t  state_nxt;
    memcard_status_pkg::resp_kind_t kind_r;
    logic                           pend_r;
    logic [4:0]                     cnt_r;
    logic [4:0]                     cnt_nxt;
    logic [7:0]                     sh_r;
    logic [2:0]                     bit_r;
    logic                           oe_r;
    logic                           done_r;
    logic                           done_nxt;
    logic [7:0]                     byte_nxt;
    logic                           rd_short_nxt;
    logic                           rd_ext_nxt;
    logic                           byte_end;
    logic                           take;
    logic [143:0]                   payload;
    logic [7:0]                     data_byte;
    logic [7:0]                     ocr_byte;
    logic [7:0]                     resel_byte;
    logic [4:0]                     gap_init;
    logic [4:0]                     wait_init;

    // Pin synchroniser
    spi_pin_sync u_sync (
        .clk_in  (CLK_IN),
        .rst_in  (RST_IN),
        .sck_in  (SCK_IN),
        .cs_n_in (CS_N_IN),
        .pins    (pins.drv)
    );

    // Status latches
    card_status_flags u_flags (
        .clk_in              (CLK_IN),
        .rst_in              (RST_IN),
        .gen_err_in          (GEN_ERR_IN),
        .spec_ro_mismatch_in (SPEC_RO_MISMATCH_IN),
        .spec_guard_undo_in  (SPEC_GUARD_UNDO_IN),
        .erase_partial_in    (ERASE_PARTIAL_IN),
        .lock_seq_err_in     (LOCK_SEQ_ERR_IN),
        .lock_pwd_err_in     (LOCK_PWD_ERR_IN),
        .erase_abandon_in    (ERASE_ABANDON_IN),
        .reset_cmd_in        (RESET_CMD_IN),
        .init_done_in        (INIT_DONE_IN),
        .password_locked_in  (PASSWORD_LOCKED_IN),
        .st                  (st.flags)
    );

    // Request handshake and byte boundary
    assign RESP_READY_OUT = (state_r == memcard_status_pkg::ST_IDLE) && !pend_r;
    assign take           = RESP_REQ_IN && RESP_READY_OUT;
    assign byte_end = pins.sck_fall && pins.cs_low && (bit_r == memcard_status_pkg::BIT_LAST);

    // Byte sources, MSB first
    assign payload    = {(kind_r == memcard_status_pkg::KIND_IDENT) ? IDENT_REG_IN : SPEC_REG_IN,
                         REG_CRC_IN};
    assign data_byte  = payload[{cnt_r, 3'h0} +: 8];
    assign ocr_byte   = OCR_IN[{cnt_r[1:0], 3'h0} +: 8];
    assign resel_byte = BUSY_IN ? memcard_status_pkg::BUSY_BYTE : memcard_status_pkg::IDLE_BYTE;
    assign gap_init   = 5'(RESP_GAP_BYTES - 1);
    assign wait_init  = 5'(REG_WAIT_BYTES);

    // Sequencer: next byte at each boundary
    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        byte_nxt     = memcard_status_pkg::IDLE_BYTE;
        rd_short_nxt = 1'b0;
        rd_ext_nxt   = 1'b0;
        done_nxt     = 1'b0;
        if (byte_end) begin
            unique case (state_r)
                memcard_status_pkg::ST_IDLE: begin
                    if (pend_r) begin
                        state_nxt = memcard_status_pkg::ST_GAP;
                        cnt_nxt   = gap_init;
                    end
                end
                memcard_status_pkg::ST_GAP: begin
                    if (cnt_r == 5'h00) begin
                        byte_nxt     = st.short_byte; // [R17] [R7]
                        rd_short_nxt = 1'b1;          // [R9]
                        unique case (kind_r)
                            memcard_status_pkg::KIND_SHORT: begin
                                state_nxt = memcard_status_pkg::ST_IDLE;
                                done_nxt  = 1'b1;
                            end
                            memcard_status_pkg::KIND_BUSY: begin
                                state_nxt = memcard_status_pkg::ST_BUSY;
                            end
                            memcard_status_pkg::KIND_EXT: begin
                                state_nxt = memcard_status_pkg::ST_TAIL;
                            end
                            memcard_status_pkg::KIND_OCR: begin
                                state_nxt = memcard_status_pkg::ST_TAIL;
                                cnt_nxt   = memcard_status_pkg::OCR_LAST;
                            end
                            default: begin
                                state_nxt = memcard_status_pkg::ST_WAIT;
                                cnt_nxt   = wait_init;
                            end
                        endcase
                    end else begin
                        cnt_nxt = cnt_r - 5'h01;
                    end
                end
                memcard_status_pkg::ST_TAIL: begin
                    if (kind_r == memcard_status_pkg::KIND_EXT) begin
                        byte_nxt   = st.ext_byte; // [R18]
                        rd_ext_nxt = 1'b1;        // [R9] [R20]
                        state_nxt  = memcard_status_pkg::ST_IDLE;
                        done_nxt   = 1'b1;
                    end else begin
                        byte_nxt = ocr_byte;
                        cnt_nxt  = cnt_r - 5'h01;
                        if (cnt_r == 5'h00) begin
                            state_nxt = memcard_status_pkg::ST_IDLE;
                            done_nxt  = 1'b1;
                        end
                    end
                end
                memcard_status_pkg::ST_WAIT: begin
                    if (cnt_r == 5'h00) begin
                        byte_nxt  = memcard_status_pkg::START_TOKEN; // [R15]
                        state_nxt = memcard_status_pkg::ST_DATA;
                        cnt_nxt   = memcard_status_pkg::REG_LAST;
                    end else begin
                        cnt_nxt = cnt_r - 5'h01;
                    end
                end
                memcard_status_pkg::ST_DATA: begin
                    byte_nxt = data_byte;
                    cnt_nxt  = cnt_r - 5'h01;
                    if (cnt_r == 5'h00) begin
                        state_nxt = memcard_status_pkg::ST_IDLE;
                        done_nxt  = 1'b1;
                    end
                end
                memcard_status_pkg::ST_BUSY: begin
                    byte_nxt = resel_byte; // [R19]
                    if (!BUSY_IN) begin
                        state_nxt = memcard_status_pkg::ST_IDLE;
                        done_nxt  = 1'b1;
                    end
                end
                default: begin
                    state_nxt = memcard_status_pkg::ST_IDLE;
                end
            endcase
        end
        // Deselect abandons any transfer except a busy wait
        if (pins.cs_rise && (state_r != memcard_status_pkg::ST_BUSY)) begin // [R11]
            state_nxt = memcard_status_pkg::ST_IDLE;
        end
    end

    assign st.rd_short = rd_short_nxt;
    assign st.rd_ext   = rd_ext_nxt;

    // Sequencer registers and pending request
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_r <= memcard_status_pkg::ST_IDLE;
            cnt_r   <= 5'h00;
            pend_r  <= 1'b0;
            kind_r  <= memcard_status_pkg::KIND_SHORT;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            done_r  <= done_nxt;
            if (take) begin
                pend_r <= 1'b1;
                kind_r <= memcard_status_pkg::resp_kind_t'(RESP_KIND_IN); // [R16]
            end else if (state_nxt != memcard_status_pkg::ST_IDLE || pins.cs_rise) begin
                pend_r <= 1'b0;
            end
        end
    end

    // Shifter: next bit on each serial clock fall
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            sh_r  <= memcard_status_pkg::IDLE_BYTE;
            bit_r <= 3'h0;
        end else if (pins.cs_fall) begin
            bit_r <= 3'h0;
            sh_r  <= (state_r == memcard_status_pkg::ST_BUSY) ? resel_byte
                   : memcard_status_pkg::IDLE_BYTE; // [R14] [R13]
        end else if (pins.sck_fall && pins.cs_low) begin
            bit_r <= bit_r + 3'h1;
            sh_r  <= byte_end ? byte_nxt : {sh_r[6:0], 1'b1};
        end
    end

    // Output enable follows chip select one clock later
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= pins.cs_low; // [R12] [R14]
        end
    end

    assign CARD_SERIAL_OUT    = sh_r[7];
    assign CARD_SERIAL_OE_OUT = oe_r;
    assign RESP_DONE_OUT      = done_r;
    assign IDLE_STATE_OUT     = st.idle;
    assign TX_ACTIVE_OUT      = (state_r != memcard_status_pkg::ST_IDLE);

endmodule : memcard_spi_status_busy_timing

// File: sim/memcard_spi_status_busy_timing_properties.sv
// Port-level checks for the card response block
`timescale 1ns/1ps
module memcard_status_checker (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Pins, handshake, idle
    input wire logic CS_N_IN,
    input wire logic CARD_SERIAL_OUT,
    input wire logic CARD_SERIAL_OE_OUT,
    input wire logic RESP_REQ_IN,
    input wire logic RESP_READY_OUT,
    input wire logic RESP_DONE_OUT,
    input wire logic BUSY_IN,
    input wire logic TX_ACTIVE_OUT,
    input wire logic RESET_CMD_IN,
    input wire logic INIT_DONE_IN,
    input wire logic IDLE_STATE_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // Busy parked deselected, then reselected
    sequence s_off; (CS_N_IN && TX_ACTIVE_OUT) [*6]; endsequence
    sequence s_on; (!CS_N_IN && BUSY_IN) [*6]; endsequence
    property p_resume; s_off ##1 s_on |-> CARD_SERIAL_OE_OUT && !CARD_SERIAL_OUT; endproperty
    property p_release; CS_N_IN [*6] |-> !CARD_SERIAL_OE_OUT; endproperty
    property p_oe_rise; $rose(CARD_SERIAL_OE_OUT) |-> !CS_N_IN && !$past(CS_N_IN); endproperty
    property p_idle_exit; INIT_DONE_IN && !RESET_CMD_IN |=> !IDLE_STATE_OUT; endproperty
    property p_idle_set; RESET_CMD_IN && !INIT_DONE_IN |=> IDLE_STATE_OUT; endproperty
    property p_idle_keep; !RESET_CMD_IN && !INIT_DONE_IN |=> $stable(IDLE_STATE_OUT); endproperty
    property p_taken; RESP_REQ_IN && RESP_READY_OUT && !CS_N_IN |=> !RESP_READY_OUT; endproperty
    property p_done; RESP_DONE_OUT |-> !TX_ACTIVE_OUT ##1 !RESP_DONE_OUT; endproperty
    a_resume: assert property (p_resume) else $error("busy not resumed");
    a_release: assert property (p_release) else $error("line not released");
    a_oe_rise: assert property (p_oe_rise) else $error("drive without select");
    a_idle_exit: assert property (p_idle_exit) else $error("idle stuck");
    a_idle_set: assert property (p_idle_set) else $error("idle not set");
    a_idle_keep: assert property (p_idle_keep) else $error("idle moved");
    a_taken: assert property (p_taken) else $error("request lost");
    a_done: assert property (p_done) else $error("done while active");
endmodule : memcard_status_checker
bind memcard_spi_status_busy_timing memcard_status_checker i_memcard_status_checker (
    .CLK_IN, .RST_IN, .CS_N_IN, .CARD_SERIAL_OUT, .CARD_SERIAL_OE_OUT, .RESP_REQ_IN,
    .RESP_READY_OUT, .RESP_DONE_OUT, .BUSY_IN, .TX_ACTIVE_OUT, .RESET_CMD_IN,
    .INIT_DONE_IN, .IDLE_STATE_OUT);

// File: sim/spi_host_model.sv
// Host master clocking bytes over the serial pins
`timescale 1ns/1ps
module spi_host_model (
    // Serial pins
    output logic      sck_out,
    output logic      cs_n_out,
    input  wire logic miso_in,
    input  wire logic oe_in
);
    wire logic line_lvl = oe_in ? miso_in : 1'b1; // Released line reads high
    initial sck_out = 1'b0;
    initial cs_n_out = 1'b1;
    // One byte MSB first, sampled on rising clock
    task automatic xfer(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #32 sck_out = 1'b1;
            b[i] = line_lvl;
            #32 sck_out = 1'b0;
        end
    endtask : xfer
    // Gap byte, then select change
    task automatic sel(input logic n);
        logic [7:0] g;
        xfer(g);
        cs_n_out = n;
        #400;
    endtask : sel
endmodule : spi_host_model

// File: sim/tb_memcard_spi_status_busy_timing.sv
// Bench for the card response block
`timescale 1ns/1ps
module tb_memcard_spi_status_busy_timing;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        req = 1'b0;
    logic        busy = 1'b0;
    logic        lck = 1'b0;
    logic [2:0]  kind = 3'h0;
    logic [18:0] ev = '0;
    logic [7:0]  b;
    wire         sck, cs_n, dout, oe, idle;
    int          failures = 0;
    int          tests_run = 0;
    always #2.5 clk = ~clk;
    memcard_spi_status_busy_timing i_memcard_spi_status_busy_timing (
        .CLK_IN(clk), .RST_IN(rst), .SCK_IN(sck), .CS_N_IN(cs_n), .CARD_SERIAL_OUT(dout),
        .CARD_SERIAL_OE_OUT(oe), .RESP_REQ_IN(req), .RESP_KIND_IN(kind), .RESP_READY_OUT(),
        .RESP_DONE_OUT(), .BUSY_IN(busy), .OCR_IN(32'hA5000000), .SPEC_REG_IN({8'h5C, 120'h0}),
        .IDENT_REG_IN({8'hC3, 120'h0}), .REG_CRC_IN(16'h1234), .GEN_ERR_IN(ev[10:0]),
        .SPEC_RO_MISMATCH_IN(ev[11]), .SPEC_GUARD_UNDO_IN(ev[12]), .ERASE_PARTIAL_IN(ev[13]),
        .LOCK_SEQ_ERR_IN(ev[14]), .LOCK_PWD_ERR_IN(ev[15]), .ERASE_ABANDON_IN(ev[16]),
        .RESET_CMD_IN(ev[17]), .INIT_DONE_IN(ev[18]), .PASSWORD_LOCKED_IN(lck),
        .IDLE_STATE_OUT(idle), .TX_ACTIVE_OUT());
    spi_host_model i_spi_host_model (.sck_out(sck), .cs_n_out(cs_n), .miso_in(dout), .oe_in(oe));
    // Helpers
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : cmp
    task automatic rq(input logic [2:0] k);
        @(negedge clk);
        req = 1'b1;
        kind = k;
        @(negedge clk);
        req = 1'b0;
    endtask : rq
    task automatic tok(input logic [7:0] e);
        b = 8'hFF;
        for (int n = 0; n < 10 && b === 8'hFF; n++) i_spi_host_model.xfer(b);
        cmp(b, e);
    endtask : tok
    task automatic nxt(input logic [7:0] e);
        i_spi_host_model.xfer(b);
        cmp(b, e);
    endtask : nxt
    task automatic pulse(input int i);
        @(negedge clk);
        ev[i] = 1'b1;
        @(negedge clk);
        ev = '0;
    endtask : pulse
    task automatic tally_and_finish;
        if (failures == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // Watchdog
    initial begin
        #400000;
        failures++;
        tally_and_finish();
    end
    // Test sequence
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        i_spi_host_model.sel(1'b0);
        rq(3'h0);
        tok(8'h01);
        pulse(18);
        pulse(0);
        rq(3'h0);
        tok(8'h40);
        lck = 1'b1;
        for (int i = 0; i < 17; i++) pulse(i);
        rq(3'h2);
        tok(8'h7E);
        nxt(8'hFF);
        rq(3'h2);
        tok(8'h00);
        nxt(8'h01);
        lck = 1'b0;
        pulse(12);
        rq(3'h2);
        tok(8'h00);
        nxt(8'h80);
        pulse(17);
        cmp({7'h00, idle}, 8'h01);
        pulse(18);
        rq(3'h3);
        tok(8'h00);
        nxt(8'hA5);
        repeat (3) i_spi_host_model.xfer(b);
        for (int k = 4; k < 6; k++) begin
            rq(3'(k));
            tok(8'h00);
            tok(8'hFE);
            nxt(k == 4 ? 8'h5C : 8'hC3);
            repeat (17) i_spi_host_model.xfer(b);
        end
        @(negedge clk);
        busy = 1'b1;
        rq(3'h1);
        tok(8'h00);
        nxt(8'h00);
        i_spi_host_model.sel(1'b1);
        i_spi_host_model.sel(1'b0);
        nxt(8'h00);
        @(negedge clk);
        busy = 1'b0;
        for (int n = 0; n < 4 && b === 8'h00; n++) i_spi_host_model.xfer(b);
        cmp(b, 8'hFF);
        tally_and_finish();
    end
endmodule : tb_memcard_spi_status_busy_timing
